// ==== hw/fcbu_unit.sv ====
// FPU conditional branch unit: decode, evaluation and fetch redirect
// How it works
// - Decode FPU opcode with bit-clear 01001 and bit-set 01101; bits 20:16 select register.
// - Bit-clear branch is true when register bit 0 is zero.
// - Bit-set branch is true when register bit 0 is one.
// - False condition leaves the program counter sequential.
// - Target is sign-extended offset times four plus slot address.
// - Register-bit branches always execute the delay slot first.
// - Coprocessor disabled raises coprocessor-unusable instead of evaluating, unless a current-release reserved-instruction fault applies.
// - With an FPU present register-bit branches raise reserved-instruction only from the current-release delay-slot check.
// - Only bit 0 of the register matters, whatever the data format.
// - Current release: control transfer in a delay slot raises reserved-instruction.
// - Branches, jumps, link-without-branch, returns, wait, pause are control transfers.
// - Legacy false branch is taken after the slot when condition code is 0.
// - Likely forms nullify the slot when not taken.
// - Legacy branches select one of eight condition codes; short form means code 0.
// - Current release rejects legacy condition-code branches.
// - Legacy true forms branch when the selected code is 1.
`timescale 1ns/10ps
module fcbu_unit (
    input wire logic i_sys_clk,                          // 50 MHz core clock
    input wire logic i_rst_b,                            // Async reset, active low
    input wire logic i_valid,                            // Instruction issued this cycle
    input wire logic [31:0] i_instr,                     // Instruction word
    input wire logic [31:0] i_pc,                        // Address of the instruction
    input wire logic i_is_cti,                           // Core decode: control_transfer_instr
    input wire logic i_release6,                         // Current release mode
    input wire logic i_fpu_present,                      // FPU implemented
    input wire logic i_fpu_major_opcode_enable,                      // Coprocessor access enabled
    input wire logic [fcbu_pkg::FCBU_FPR_W-1:0] i_fpr_data, // fpu_register_file read data
    input wire logic [fcbu_pkg::FCBU_NUM_FCC-1:0] i_fcc,   // fpu_condition_signal bits
    output logic [4:0] o_fpr_sel,                        // tested_fpu_reg_field, registered
    output logic o_branch_valid,                         // Decoded branch resolved, pulse
    output logic o_taken,                                // Redirect fetch, pulse
    output logic [31:0] o_target,                        // Redirect address
    output logic o_nullify_slot,                         // Drop delay slot, pulse
    output logic o_cop_unusable,                         // Coprocessor-unusable fault, pulse
    output logic o_reserved_instr                        // Reserved-instruction fault, pulse
);
    import fcbu_pkg::*;

    logic [5:0] op;
    logic [4:0] rs;
    logic is_fpu_op, dec_clear, dec_set, dec_fcc, in_slot;
    logic [2:0] cc_sel;
    logic cc_bit, fcc_cond, bit_cond, cond;
    logic any_branch, cti_here, slot_fault, legacy_fault, cu_fault, ri_fault;
    logic [31:0] slot_pc, target;
    logic in_slot_r, in_slot_nxt;
    logic branch_valid_r, taken_r, nullify_r, cu_r, ri_r;
    logic [31:0] target_r;
    logic [4:0] fpr_sel_r;

    assign op = i_instr[FCBU_OP_HI:FCBU_OP_LO];
    assign rs = i_instr[FCBU_RS_HI:FCBU_RS_LO];
    assign is_fpu_op = i_valid && (op == FCBU_OP_FPU);
    assign dec_clear = is_fpu_op && (rs == FCBU_RS_BIT_CLEAR);
    assign dec_set = is_fpu_op && (rs == FCBU_RS_BIT_SET);
    assign dec_fcc = is_fpu_op && (rs == FCBU_RS_FCC);

    assign cc_sel = i_instr[FCBU_CC_HI:FCBU_CC_LO];
    assign cc_bit = i_fcc[cc_sel];
    // false form wants 0; true form wants 1
    assign fcc_cond = (cc_bit == i_instr[FCBU_TF_BIT]);

    // clear form true on zero; set form true on one
    assign bit_cond = dec_set ? i_fpr_data[0] : ~i_fpr_data[0];
    assign cond = dec_fcc ? fcc_cond : bit_cond;

    // slot tracking ORs the core control-transfer flag with our own branch decode
    assign any_branch = dec_clear || dec_set || dec_fcc;
    assign cti_here = i_valid && (i_is_cti || any_branch);
    // current-release slot check; legacy leaves it unchecked
    assign slot_fault = in_slot_r && cti_here && i_release6;
    // legacy forms rejected under current release
    assign legacy_fault = dec_fcc && i_release6;
    assign cu_fault = (dec_clear || dec_set || (dec_fcc && !i_release6)) && !i_fpu_major_opcode_enable && !slot_fault;
    // with an FPU, register-bit forms take reserved-instruction only from the slot check
    assign ri_fault = slot_fault || legacy_fault ||
                      ((dec_clear || dec_set) && !i_fpu_present);

    assign slot_pc = i_pc + FCBU_PC_STEP;
    assign in_slot_nxt = i_valid ? cti_here : in_slot_r;

    fcbu_target u_target (
        .i_slot_pc(slot_pc),
        .i_offset(i_instr[FCBU_OFS_HI:FCBU_OFS_LO]),
        .o_target(target)
    );

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            in_slot_r <= 1'b0;
            branch_valid_r <= 1'b0;
            taken_r <= 1'b0;
            nullify_r <= 1'b0;
            cu_r <= 1'b0;
            ri_r <= 1'b0;
            target_r <= FCBU_RESET_PC;
            fpr_sel_r <= 5'h00;
        end else begin
            in_slot_r <= in_slot_nxt;
            branch_valid_r <= any_branch && !cu_fault && !ri_fault;
            // slot kept; redirect applies after it
            taken_r <= any_branch && !cu_fault && !ri_fault && cond;
            // likely forms drop the slot when not taken
            nullify_r <= dec_fcc && !cu_fault && !ri_fault && i_instr[FCBU_ND_BIT] && !fcc_cond;
            cu_r <= cu_fault;
            ri_r <= ri_fault;
            target_r <= any_branch ? target : target_r;
            fpr_sel_r <= (dec_clear || dec_set) ? i_instr[FCBU_FT_HI:FCBU_FT_LO] : fpr_sel_r;
        end
    end

    assign o_fpr_sel = fpr_sel_r;
    assign o_branch_valid = branch_valid_r;
    assign o_taken = taken_r;
    assign o_target = target_r;
    assign o_nullify_slot = nullify_r;
    assign o_cop_unusable = cu_r;
    assign o_reserved_instr = ri_r;
endmodule // fcbu_unit

// ==== hw/fcbu_pkg.sv ====
// Package for the FPU conditional branch unit: encodings, field positions and kinds
package fcbu_pkg;
    localparam logic [5:0] FCBU_OP_FPU = 6'h11;
    localparam logic [4:0] FCBU_RS_BIT_CLEAR = 5'h09;
    localparam logic [4:0] FCBU_RS_BIT_SET = 5'h0D;
    localparam logic [4:0] FCBU_RS_FCC = 5'h08;
    localparam int FCBU_OP_HI = 31;
    localparam int FCBU_OP_LO = 26;
    localparam int FCBU_RS_HI = 25;
    localparam int FCBU_RS_LO = 21;
    localparam int FCBU_FT_HI = 20;
    localparam int FCBU_FT_LO = 16;
    localparam int FCBU_CC_HI = 20;
    localparam int FCBU_CC_LO = 18;
    localparam int FCBU_ND_BIT = 17;
    localparam int FCBU_TF_BIT = 16;
    localparam int FCBU_OFS_HI = 15;
    localparam int FCBU_OFS_LO = 0;
    localparam int FCBU_FPR_W = 64;
    localparam int FCBU_NUM_FCC = 8;
    localparam logic [31:0] FCBU_PC_STEP = 32'h00000004;
    localparam logic [31:0] FCBU_RESET_PC = 32'h00000000;
    typedef enum logic [2:0] {
        FCBU_K_NONE,
        FCBU_K_BIT_CLEAR,
        FCBU_K_BIT_SET,
        FCBU_K_FCC_FALSE,
        FCBU_K_FCC_TRUE
    } fcbu_kind_t;
endpackage

// ==== hw/fcbu_target.sv ====
// Branch target adder: offset shifted, sign-extended, added to the slot address
`timescale 1ns/10ps
module fcbu_target (
    input wire logic [31:0] i_slot_pc, // Address of the instruction after the branch
    input wire logic [15:0] i_offset,  // Raw offset field
    output logic [31:0] o_target       // Branch target
);
    import fcbu_pkg::*;
    logic [17:0] ofs18;
    logic [31:0] ofs32;
    assign ofs18 = {i_offset, 2'b00};
    assign ofs32 = {{14{ofs18[17]}}, ofs18};
    assign o_target = i_slot_pc + ofs32;
endmodule // fcbu_target

// ==== bench/fcbu_fetch_model.sv ====
// Fetch-side model: counts redirects taken from the branch unit
`timescale 1ns/10ps
module fcbu_fetch_model (
    input wire logic i_sys_clk, // Core clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic i_taken, // Redirect request
    output logic [7:0] o_redirects // Redirects accepted
);
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) o_redirects <= 8'h0;
        else if (i_taken) o_redirects <= o_redirects + 8'h1;
    end
endmodule // fcbu_fetch_model

// ==== bench/fcbu_unit_props.sv ====
// Checker for the branch unit port behaviour
`timescale 1ns/10ps
module fcbu_unit_props (
    input wire logic i_sys_clk, i_rst_b, i_valid, i_release6, i_fpu_present, i_fpu_major_opcode_enable,
    input wire logic [31:0] i_instr, i_pc, o_target,
    input wire logic [fcbu_pkg::FCBU_FPR_W-1:0] i_fpr_data,
    input wire logic o_branch_valid, o_taken, o_nullify_slot, o_cop_unusable, o_reserved_instr
);
    import fcbu_pkg::*;
    wire logic [10:0] hd = i_instr[31:21];
    wire logic bclr = i_valid && hd == {FCBU_OP_FPU, FCBU_RS_BIT_CLEAR};
    wire logic bset = i_valid && hd == {FCBU_OP_FPU, FCBU_RS_BIT_SET};
    wire logic leg = i_valid && hd == {FCBU_OP_FPU, FCBU_RS_FCC};
    wire logic [31:0] nt = i_pc + FCBU_PC_STEP + {{14{i_instr[15]}}, i_instr[15:0], 2'h0};
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    clr_one_a: assert property (bclr && i_fpr_data[0] |=> !o_taken) else $error("clear taken");
    set_zero_a: assert property (bset && !i_fpr_data[0] |=> !o_taken) else $error("set taken");
    legacy_r6_a: assert property (leg && i_release6 |=> o_reserved_instr && !o_taken)
        else $error("legacy kept");
    cop_off_a: assert property ((bclr || bset) && !i_fpu_major_opcode_enable |=> !o_branch_valid && (o_cop_unusable || o_reserved_instr))
        else $error("no cop fault");
    no_resv_a: assert property ((bclr || bset) && i_fpu_present && i_fpu_major_opcode_enable && !i_release6 |=> !o_reserved_instr)
        else $error("reserved raised");
    tgt_sum_a: assert property (o_taken |-> o_target == $past(nt)) else $error("bad target");
    taken_one_a: assert property (o_taken |-> o_branch_valid && !o_nullify_slot) else $error("bad taken");
    null_leg_a: assert property (o_nullify_slot |-> $past(leg) && $past(i_instr[17]) && !o_taken)
        else $error("stray nullify");
endmodule // fcbu_unit_props
bind fcbu_unit fcbu_unit_props i_props (.*);

// ==== bench/testbench.sv ====
// Testbench: table of branch cases, slot faults and a reset check just before finishing
`timescale 1ns/10ps
module testbench;
    import fcbu_pkg::*;
    typedef struct packed {logic [31:0] ins; logic fb; logic [7:0] fcc; logic r6; logic ce; logic [3:0] ex;} fcbu_row_t;
    localparam fcbu_row_t NOP = '{32'h0, 1'h0, 8'h0, 1'h1, 1'h1, 4'h0};
    localparam fcbu_row_t BSET = '{32'h45A50010, 1'h1, 8'h0, 1'h1, 1'h1, 4'h8};
    // Flags: taken, nullify, reserved, cop unusable
    fcbu_row_t rows [11] = '{'{32'h4523FFFF, 1'h0, 8'h0, 1'h1, 1'h1, 4'h8}, '{32'h45230004, 1'h1, 8'h0, 1'h0, 1'h1, 4'h0},
        BSET, '{32'h45A50010, 1'h0, 8'h0, 1'h1, 1'h1, 4'h0}, '{32'h45140008, 1'h0, 8'hDF, 1'h0, 1'h1, 4'h8},
        '{32'h451F0002, 1'h0, 8'h7F, 1'h0, 1'h1, 4'h4}, '{32'h45020001, 1'h0, 8'h01, 1'h0, 1'h1, 4'h4},
        '{32'h45010001, 1'h0, 8'h01, 1'h1, 1'h1, 4'h2}, '{32'h45200001, 1'h0, 8'h0, 1'h1, 1'h0, 4'h1},
        '{32'h450D0004, 1'h0, 8'h08, 1'h0, 1'h1, 4'h8}, '{32'h45000004, 1'h0, 8'h01, 1'h0, 1'h1, 4'h0}};
    logic i_sys_clk = 1'h0, i_rst_b = 1'h0, i_valid = 1'h0, i_is_cti = 1'h0, i_release6 = 1'h0, i_fpu_major_opcode_enable = 1'h0;
    logic [31:0] i_instr = 32'h0, i_pc = 32'h0, pc = 32'h0;
    logic [FCBU_FPR_W-1:0] i_fpr_data = 64'h0;
    logic [7:0] i_fcc = 8'h0;
    wire logic [7:0] redirects;
    wire logic [31:0] o_target;
    wire logic [4:0] fpr_sel;
    wire logic o_branch_valid, o_taken, o_nullify_slot, o_cop_unusable, o_reserved_instr;
    int failures = 0, samples_checked = 0;
    always #10 i_sys_clk = ~i_sys_clk;
    fcbu_unit i_fcbu_unit (.*, .i_fpu_present(1'h1), .o_fpr_sel(fpr_sel));
    fcbu_fetch_model i_fcbu_fetch_model (.i_sys_clk, .i_rst_b, .i_taken(o_taken), .o_redirects(redirects));
    task automatic drive(input fcbu_row_t r, input logic control_transfer_instr);
        @(posedge i_sys_clk);
        i_valid <= 1'h1;
        i_instr <= r.ins;
        i_pc <= pc;
        // Upper bits opposite to bit 0
        i_fpr_data <= r.fb ? 64'h1 : 64'hFFFFFFFFFFFFFFFE;
        i_fcc <= r.fcc;
        i_release6 <= r.r6;
        i_fpu_major_opcode_enable <= r.ce;
        i_is_cti <= control_transfer_instr;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic results;
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_rst_b <= 1'h1;
        for (int k = 0; k < 11; k++) begin
            pc = 32'h1000 + 32'(k) * 32'h10;
            drive(rows[k], 1'h0);
            drive(NOP, 1'h0);
            #1;
            chk("flags", 32'(rows[k].ex), {o_taken, o_nullify_slot, o_reserved_instr, o_cop_unusable});
            if (rows[k].ex[3]) chk("target", pc + 32'h4 + {{14{rows[k].ins[15]}}, rows[k].ins[15:0], 2'h0}, o_target);
            chk("valid", 32'(rows[k].ex[1:0] == 2'h0), {31'h0, o_branch_valid});
            if (rows[k].ins[25:21] != FCBU_RS_FCC) chk("fpr_sel", 32'(rows[k].ins[20:16]), 32'(fpr_sel));
        end
        for (int j = 0; j < 2; j++) begin
            drive(BSET, 1'h0);
            drive(j ? rows[8] : NOP, 1'(j == 0));
            #1;
            chk("slot_taken", 32'h1, {31'h0, o_taken});
            drive(NOP, 1'h0);
            #1;
            chk("slot_fault", 32'h1, {31'h0, o_reserved_instr});
        end
        chk("redirects", 32'h6, {24'h0, redirects});
        @(posedge i_sys_clk);
        i_rst_b <= 1'h0;
        #1;
        chk("reset_target", 32'h0, o_target);
        results();
    end
    initial begin
        repeat (2000) @(posedge i_sys_clk);
        failures++;
        results();
    end
endmodule // testbench
